// ---- core/dcr_channel_bank.sv ----
// per-channel control and status register bank with extended-space window
`timescale 1ns/1ps
`include "dcr_map.svh"
// Function
// - jumper bit per channel: 1 programmable, 0 fixed
// - jumper-fixed channel takes terminal mode, ignores writes
// - pending bit shows value awaiting trigger
// - immediate write outputs now, clears pending
// - triggered write holds value, sets pending
// - eight-channel build reads ones for channels 9-16
// - mode bit 1 voltage, 0 current
// - mode read returns effective mode
// - relay bit 1 open, 0 closed
// - relay write completes at once, settles later
// - relay read returns programmed state
// - control bit 4 enables non-volatile alteration
// - non-volatile change needs enable and cal jumper
// - window field selects page at 20-3E
// - window values map to fixed pages
// - each window step moves 32 bytes
// - triggered data applies after next trigger
// - configuration field ones for eight channels
module dcr_channel_bank #(
  parameter int CHANNELS = 16,
  parameter int RELAY_SETTLE_CYCLES = `DCR_RELAY_SETTLE_US * `DCR_CLK_MHZ
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic eight_channel_i,
  input wire logic [CHANNELS-1:0] select_jumper_i,
  input wire logic [CHANNELS-1:0] vi_jumper_i,
  input wire logic [2:0] terminal_id_i,
  input wire logic cal_jumper_i,
  input wire logic trigger_i,
  input wire dcr_pkg::dcr_bus_req_t bus_req_i,
  output logic bus_ready_o,
  output logic bus_ack_o,
  output logic [15:0] bus_rdata_o,
  output dcr_pkg::dcr_ext_req_t ext_req_o,
  input wire logic [15:0] ext_rdata_i,
  output dcr_pkg::dcr_dac_load_t dac_load_o,
  output logic [CHANNELS-1:0] channel_mode_o,
  output logic [CHANNELS-1:0] relay_open_o,
  output logic relay_busy_o,
  output logic nv_write_enable_o
);
  localparam logic [CHANNELS-1:0] HIGH_CH = CHANNELS'(`DCR_HIGH_CHANNELS);
  localparam int SETTLE_W = $clog2(RELAY_SETTLE_CYCLES + 1);

  dcr_pkg::dcr_state_t state_ff;
  dcr_pkg::dcr_state_t nxt_state;
  dcr_pkg::dcr_bus_req_t req_ff;
  dcr_pkg::dcr_dac_load_t dac_ff;
  dcr_pkg::dcr_dac_load_t nxt_dac;
  logic req_vld_ff;
  logic ack_ff;
  logic [15:0] rdata_ff;
  logic [CHANNELS-1:0] pending_ff;
  logic [CHANNELS-1:0] sweep_mask_ff;
  logic [CHANNELS-1:0] mode_ff;
  logic [CHANNELS-1:0] relay_ff;
  logic [`DCR_NV_EN_BIT:0] card_ctrl_ff;
  logic [3:0] sweep_ch_ff;
  logic trig_pend_ff;
  logic [SETTLE_W-1:0] settle_ff;

  // decode of the request held in the stage register
  wire take = (bus_req_i.wr | bus_req_i.rd) & bus_ready_o;
  wire [3:0] window = card_ctrl_ff[`DCR_WIN_MSB:0];
  wire in_window = req_ff.addr >= `DCR_OFS_WINDOW_BASE;
  wire [3:0] req_ch = req_ff.addr[4:1];
  wire [5:0] local_addr = in_window ? {1'b0, req_ff.addr[4:0]} : req_ff.addr;
  wire is_local = !in_window || (window == `DCR_WIN_SHORT_LOW);
  wire is_imm = in_window && (window == `DCR_WIN_IMMEDIATE);
  wire is_trg = in_window && (window == `DCR_WIN_TRIGGERED);
  wire is_undef = in_window && ((window == `DCR_WIN_UNDEF_A) || (window == `DCR_WIN_UNDEF_B));
  wire is_nv = in_window && (window >= `DCR_WIN_NV_FIRST);
  wire is_ext = in_window && !is_local && !is_imm && !is_trg && !is_undef;
  wire nv_allow = card_ctrl_ff[`DCR_NV_EN_BIT] & cal_jumper_i;
  wire wr_now = req_vld_ff & req_ff.wr;
  wire rd_now = req_vld_ff & req_ff.rd;
  wire wr_mode = wr_now & is_local & (local_addr == `DCR_OFS_MODE);
  wire wr_relay = wr_now & is_local & (local_addr == `DCR_OFS_RELAY);
  wire wr_ctrl = wr_now & is_local & (local_addr == `DCR_OFS_CARD_CTRL);
  wire wr_imm = wr_now & is_imm;
  wire wr_trg = wr_now & is_trg;
  wire [CHANNELS-1:0] ch_onehot = CHANNELS'(1) << req_ch;
  wire [CHANNELS-1:0] hi_fill = eight_channel_i ? HIGH_CH : '0;
  wire [CHANNELS-1:0] writable = ~hi_fill;
  wire [CHANNELS-1:0] mode_wr_mask = writable & select_jumper_i;
  wire [CHANNELS-1:0] eff_mode = (select_jumper_i & mode_ff) | (~select_jumper_i & vi_jumper_i);
  wire [2:0] cfg_field = eight_channel_i ? 3'h7 : 3'h0;
  wire sweep_start = (state_ff == dcr_pkg::DCR_IDLE) & !req_vld_ff & (trigger_i | trig_pend_ff);
  wire sweep_last = sweep_ch_ff == 4'(CHANNELS - 1);
  wire [3:0] mem_rd_addr = sweep_ch_ff;
  wire [15:0] mem_rd_data;

  logic [15:0] local_rdata;
  always_comb begin
    local_rdata = 16'h0000;
    case (local_addr)
      `DCR_OFS_CARD_CONFIG: local_rdata = {10'h000, cfg_field, terminal_id_i};
      `DCR_OFS_JUMPER: local_rdata = 16'(select_jumper_i | hi_fill);
      `DCR_OFS_PENDING: local_rdata = 16'(pending_ff | hi_fill);
      `DCR_OFS_MODE: local_rdata = 16'(eff_mode | hi_fill);
      `DCR_OFS_RELAY: local_rdata = 16'(relay_ff | hi_fill);
      `DCR_OFS_CARD_CTRL: local_rdata = 16'(card_ctrl_ff);
      default: local_rdata = 16'h0000;
    endcase
  end

  wire [15:0] rd_mux = is_local ? local_rdata : (is_ext ? ext_rdata_i : 16'h0000);

  // request stage: one request in flight, refused while a trigger sweep runs
  assign bus_ready_o = (state_ff == dcr_pkg::DCR_IDLE) & !req_vld_ff & !sweep_start;
  assign bus_ack_o = ack_ff;
  assign bus_rdata_o = rdata_ff;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_ff <= '0;
      req_vld_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      req_vld_ff <= take;
      ack_ff <= req_vld_ff;
      if (take) begin
        req_ff <= bus_req_i;
      end
      if (rd_now) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // window forwards the page number as the upper address bits
  always_comb begin
    ext_req_o = '0;
    ext_req_o.addr = {window, req_ff.addr[4:0]};
    ext_req_o.wdata = req_ff.wdata;
    ext_req_o.rd = rd_now & is_ext;
    ext_req_o.wr = wr_now & is_ext & (!is_nv | nv_allow);
  end

  // control registers; upper channels keep their reset value in eight-channel builds
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ff <= CHANNELS'(`DCR_RST_MODE);
      relay_ff <= CHANNELS'(`DCR_RST_RELAY);
      card_ctrl_ff <= `DCR_RST_CARD_CTRL;
    end else begin
      // jumper-fixed channels keep their programmed bit so a later switch back is predictable
      if (wr_mode) begin
        mode_ff <= (req_ff.wdata[CHANNELS-1:0] & mode_wr_mask) | (mode_ff & ~mode_wr_mask);
      end
      if (wr_relay) begin
        relay_ff <= (req_ff.wdata[CHANNELS-1:0] & writable) | (relay_ff & ~writable);
      end
      if (wr_ctrl) begin
        card_ctrl_ff <= req_ff.wdata[`DCR_NV_EN_BIT:0];
      end
    end
  end

  // relay write is acknowledged at once; busy only reports the settle time
  wire relay_change = wr_relay & ((req_ff.wdata[CHANNELS-1:0] & writable) != (relay_ff & writable));
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_ff <= '0;
    end else if (relay_change) begin
      settle_ff <= SETTLE_W'(RELAY_SETTLE_CYCLES);
    end else if (settle_ff != '0) begin
      settle_ff <= settle_ff - SETTLE_W'(1);
    end
  end

  assign relay_busy_o = settle_ff != '0;
  assign channel_mode_o = eff_mode;
  assign relay_open_o = relay_ff;
  assign nv_write_enable_o = nv_allow;

  // pending bits: a triggered write sets, an immediate write or a sweep clears
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_pend
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pending_ff[g] <= 1'b0;
        end else if (wr_trg && ch_onehot[g]) begin
          pending_ff[g] <= 1'b1;
        end else if (wr_imm && ch_onehot[g]) begin
          pending_ff[g] <= 1'b0;
        end else if (sweep_start) begin
          pending_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  dcr_mem #(
    .WIDTH(16),
    .DEPTH(CHANNELS),
    .AW(4)
  ) u_trig_mem (
    .clock_i(clock_i),
    .wr_en_i(wr_trg),
    .wr_addr_i(req_ch),
    .wr_data_i(req_ff.wdata),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd_data)
  );

  // trigger sweep: read each channel, load it if it was pending at the trigger
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dcr_pkg::DCR_IDLE: begin
        if (sweep_start) begin
          nxt_state = dcr_pkg::DCR_READ;
        end
      end
      dcr_pkg::DCR_READ: nxt_state = dcr_pkg::DCR_LOAD;
      dcr_pkg::DCR_LOAD: nxt_state = sweep_last ? dcr_pkg::DCR_IDLE : dcr_pkg::DCR_READ;
      default: nxt_state = dcr_pkg::DCR_IDLE;
    endcase
  end

  always_comb begin
    nxt_dac = '0;
    nxt_dac.chan = dac_ff.chan;
    nxt_dac.value = dac_ff.value;
    if (wr_imm) begin
      nxt_dac.load = 1'b1;
      nxt_dac.chan = req_ch;
      nxt_dac.value = req_ff.wdata;
    end else if ((state_ff == dcr_pkg::DCR_LOAD) && sweep_mask_ff[sweep_ch_ff]) begin
      nxt_dac.load = 1'b1;
      nxt_dac.chan = sweep_ch_ff;
      nxt_dac.value = mem_rd_data;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= dcr_pkg::DCR_IDLE;
      dac_ff <= '0;
      sweep_mask_ff <= '0;
      sweep_ch_ff <= 4'h0;
      trig_pend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dac_ff <= nxt_dac;
      if (sweep_start) begin
        sweep_mask_ff <= pending_ff;
        sweep_ch_ff <= 4'h0;
        trig_pend_ff <= 1'b0;
      end else begin
        // a trigger during a sweep or a bus request waits its turn instead of being lost
        if (trigger_i) begin
          trig_pend_ff <= 1'b1;
        end
        if (state_ff == dcr_pkg::DCR_LOAD) begin
          sweep_ch_ff <= sweep_ch_ff + 4'h1;
        end
      end
    end
  end

  assign dac_load_o = dac_ff;
endmodule

// ---- core/dcr_map.svh ----
// register offsets, field positions, reset values and timing counts of the channel bank
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_OFS_CARD_CONFIG 6'h0A
`define DCR_OFS_JUMPER 6'h16
`define DCR_OFS_PENDING 6'h18
`define DCR_OFS_MODE 6'h1A
`define DCR_OFS_RELAY 6'h1C
`define DCR_OFS_CARD_CTRL 6'h1E
`define DCR_OFS_WINDOW_BASE 6'h20
`define DCR_NV_EN_BIT 4
`define DCR_WIN_MSB 3
`define DCR_CFG_LSB 3
`define DCR_CFG_MSB 5
`define DCR_WIN_SHORT_LOW 4'h0
`define DCR_WIN_SHORT_HIGH 4'h1
`define DCR_WIN_IMMEDIATE 4'h2
`define DCR_WIN_TRIGGERED 4'h3
`define DCR_WIN_UNDEF_A 4'h6
`define DCR_WIN_UNDEF_B 4'h7
`define DCR_WIN_NV_FIRST 4'h8
`define DCR_RST_MODE 16'hFFFF
`define DCR_RST_RELAY 16'hFFFF
`define DCR_RST_CARD_CTRL 5'h00
`define DCR_HIGH_CHANNELS 16'hFF00
`define DCR_RELAY_SETTLE_US 5000
`define DCR_CLK_MHZ 20
`endif

// ---- core/dcr_mem.sv ----
// small one-write one-read memory holding the triggered output values
`timescale 1ns/1ps
module dcr_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  // no reset: contents only reach the output after a write has set the pending bit
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_ff <= mem_ff[rd_addr_i];
  end

  assign rd_data_o = rd_data_ff;
endmodule

// ---- core/dcr_pkg.sv ----
// types shared by the channel control bank, its checks, its bench and the extended-space model
package dcr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } dcr_bus_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [15:0] wdata;
  } dcr_ext_req_t;

  typedef struct packed {
    logic load;
    logic [3:0] chan;
    logic [15:0] value;
  } dcr_dac_load_t;

  typedef enum logic [1:0] {
    DCR_IDLE = 2'b00,
    DCR_READ = 2'b01,
    DCR_LOAD = 2'b11
  } dcr_state_t;
endpackage

// ---- verification/dcr_channel_bank_properties.sv ----
// concurrent checks on the channel bank ports
`timescale 1ns/1ps
module dcr_channel_bank_properties #(
  parameter int CHANNELS = 16,
  parameter int RELAY_SETTLE_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic eight_channel_i,
  input wire logic [CHANNELS-1:0] select_jumper_i,
  input wire logic [CHANNELS-1:0] vi_jumper_i,
  input wire logic cal_jumper_i,
  input wire dcr_pkg::dcr_bus_req_t bus_req_i,
  input wire logic bus_ready_o,
  input wire logic bus_ack_o,
  input wire dcr_pkg::dcr_ext_req_t ext_req_o,
  input wire dcr_pkg::dcr_dac_load_t dac_load_o,
  input wire logic [CHANNELS-1:0] channel_mode_o,
  input wire logic [CHANNELS-1:0] relay_open_o,
  input wire logic relay_busy_o,
  input wire logic nv_write_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  chk_ack_two_later: assert property ((bus_req_i.wr || bus_req_i.rd) && bus_ready_o |=>
    !bus_ready_o && !bus_ack_o ##1 bus_ack_o) else $error("ack not two cycles after take");
  chk_jumper_mode: assert property (eight_channel_i ||
    ((channel_mode_o ^ vi_jumper_i) & ~select_jumper_i) == '0) else $error("jumper mode lost");
  chk_upper_relay: assert property (eight_channel_i |-> &relay_open_o[CHANNELS-1:8])
    else $error("upper relay bits not ones");
  chk_busy_follows: assert property ($changed(relay_open_o) |-> ##1 relay_busy_o)
    else $error("relay busy missing after change");
  chk_busy_holds: assert property ($rose(relay_busy_o) |-> relay_busy_o [*8])
    else $error("relay busy too short");
  chk_load_single: assert property (dac_load_o.load |=> !dac_load_o.load)
    else $error("load pulses back to back");
  chk_ext_page: assert property (ext_req_o.rd || ext_req_o.wr |->
    !(ext_req_o.addr[8:5] inside {4'h0, 4'h2, 4'h3, 4'h6, 4'h7})) else $error("bad ext page");
  chk_nv_gate: assert property (ext_req_o.wr && ext_req_o.addr[8] |-> nv_write_enable_o)
    else $error("nv write while disabled");
  chk_nv_cal: assert property (nv_write_enable_o |-> cal_jumper_i)
    else $error("nv enable without cal jumper");
endmodule

// ---- verification/dcr_channel_bank_tb.sv ----
// self-checking bench for the channel control bank
`timescale 1ns/1ps
`include "dcr_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module dcr_channel_bank_tb;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic eight_channel_i = 1'b0;
  logic [15:0] select_jumper_i = 16'hFFFF;
  logic [15:0] vi_jumper_i = 16'h0000;
  logic [2:0] terminal_id_i = 3'h5;
  logic cal_jumper_i = 1'b0;
  logic trigger_i = 1'b0;
  dcr_pkg::dcr_bus_req_t bus_req_i = '0;
  logic bus_ready_o, bus_ack_o, relay_busy_o, nv_write_enable_o;
  logic [15:0] bus_rdata_o, ext_rdata_i, channel_mode_o, relay_open_o, q, m, r, v;
  logic [3:0] a, b;
  dcr_pkg::dcr_ext_req_t ext_req_o;
  dcr_pkg::dcr_dac_load_t dac_load_o;
  dcr_pkg::dcr_dac_load_t loads [$];
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #25 clock_i = ~clock_i;
  dcr_channel_bank #(.CHANNELS(16), .RELAY_SETTLE_CYCLES(20)) dcr_channel_bank_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .eight_channel_i(eight_channel_i),
    .select_jumper_i(select_jumper_i), .vi_jumper_i(vi_jumper_i),
    .terminal_id_i(terminal_id_i), .cal_jumper_i(cal_jumper_i), .trigger_i(trigger_i),
    .bus_req_i(bus_req_i), .bus_ready_o(bus_ready_o), .bus_ack_o(bus_ack_o),
    .bus_rdata_o(bus_rdata_o), .ext_req_o(ext_req_o), .ext_rdata_i(ext_rdata_i),
    .dac_load_o(dac_load_o), .channel_mode_o(channel_mode_o), .relay_open_o(relay_open_o),
    .relay_busy_o(relay_busy_o), .nv_write_enable_o(nv_write_enable_o));
  dcr_ext_model dcr_ext_model_i (.clock_i(clock_i), .req_i(ext_req_o), .rdata_o(ext_rdata_i));
  always @(posedge clock_i) begin
    cyc++;
    if (dac_load_o.load === 1'b1) loads.push_back(dac_load_o);
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  function automatic logic [15:0] eff_mode(logic [15:0] p, logic [15:0] s, logic [15:0] vi);
    return (p & s) | (vi & ~s);
  endfunction
  function automatic logic [15:0] win_exp(logic [3:0] w, logic [4:0] o, logic [15:0] loc);
    if (w == 4'h0) return loc;
    if (w inside {4'h2, 4'h3, 4'h6, 4'h7}) return 16'h0000;
    return 16'hA000 | {8'h00, w, o[4:1]};
  endfunction
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic eight);
    reset_n_i <= 1'b0;
    eight_channel_i <= eight;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
  endtask
  // request held until the edge that sees ready, released on that same edge
  task automatic xfer(input logic w, input logic [5:0] ad, input logic [15:0] d);
    logic rdy;
    int n;
    n = 0;
    @(posedge clock_i);
    bus_req_i <= '{wr: w, rd: !w, addr: ad, wdata: d};
    do begin
      #1 rdy = bus_ready_o;
      @(posedge clock_i);
      n++;
    end while (!rdy && n < 100);
    bus_req_i <= '0;
    @(posedge clock_i);
    #1 `CHK("ack", 1'b1, bus_ack_o)
    q = bus_rdata_o;
  endtask
  task automatic rchk(input string nm, input logic [5:0] ad, input logic [15:0] e);
    xfer(1'b0, ad, 16'h0000);
    `CHK(nm, e, q)
  endtask
  task automatic lchk(input logic [3:0] c, input logic [15:0] val);
    dcr_pkg::dcr_dac_load_t e, g;
    e = '{load: 1'b1, chan: c, value: val};
    g = '0;
    if (loads.size() > 0) g = loads.pop_front();
    `CHK("load", e, g)
  endtask
  task automatic fire();
    @(posedge clock_i);
    trigger_i <= 1'b1;
    @(posedge clock_i);
    trigger_i <= 1'b0;
    repeat (40) @(posedge clock_i);
  endtask
  initial begin
    void'($urandom(32'h7E233D2E));
    do_reset(1'b0);
    rchk("mode", `DCR_OFS_MODE, `DCR_RST_MODE);
    rchk("relay", `DCR_OFS_RELAY, `DCR_RST_RELAY);
    rchk("pend", `DCR_OFS_PENDING, 16'h0000);
    rchk("ctrl", `DCR_OFS_CARD_CTRL, 16'h0000);
    rchk("cfg", `DCR_OFS_CARD_CONFIG, 16'h0005);
    rchk("unmap", 6'h10, 16'h0000);
    $display("reset test done");
    repeat (4) begin
      @(posedge clock_i);
      select_jumper_i <= 16'($urandom);
      vi_jumper_i <= 16'($urandom);
      m = 16'($urandom);
      xfer(1'b1, `DCR_OFS_MODE, m);
      xfer(1'b1, `DCR_OFS_JUMPER, ~select_jumper_i);
      rchk("jmpr", `DCR_OFS_JUMPER, select_jumper_i);
      rchk("mode", `DCR_OFS_MODE, eff_mode(m, select_jumper_i, vi_jumper_i));
      `CHK("mode_o", eff_mode(m, select_jumper_i, vi_jumper_i), channel_mode_o)
    end
    select_jumper_i <= 16'hFFFF;
    xfer(1'b1, `DCR_OFS_MODE, 16'h0000);
    select_jumper_i <= 16'h00FF;
    xfer(1'b1, `DCR_OFS_MODE, 16'hFFFF);
    select_jumper_i <= 16'hFFFF;
    rchk("mode_keep", `DCR_OFS_MODE, 16'h00FF);
    $display("mode test done");
    r = 16'($urandom) & 16'hFFFE;
    xfer(1'b1, `DCR_OFS_RELAY, r);
    repeat (2) @(posedge clock_i);
    #1 `CHK("busy", 1'b1, relay_busy_o)
    `CHK("relay_o", r, relay_open_o)
    rchk("relay", `DCR_OFS_RELAY, r);
    repeat (25) @(posedge clock_i);
    #1 `CHK("idle", 1'b0, relay_busy_o)
    $display("relay test done");
    xfer(1'b1, `DCR_OFS_CARD_CTRL, 16'h0003);
    a = 4'($urandom);
    b = a + 4'h1;
    v = 16'($urandom);
    xfer(1'b1, {1'b1, a, 1'b0}, v);
    xfer(1'b1, {1'b1, b, 1'b0}, ~v);
    rchk("pend", `DCR_OFS_PENDING, (16'h0001 << a) | (16'h0001 << b));
    `CHK("early", 0, loads.size())
    xfer(1'b1, `DCR_OFS_CARD_CTRL, 16'h0002);
    xfer(1'b1, {1'b1, a, 1'b0}, v ^ 16'h00FF);
    @(posedge clock_i);
    #1 lchk(a, v ^ 16'h00FF);
    rchk("pend", `DCR_OFS_PENDING, 16'h0001 << b);
    fire();
    lchk(b, ~v);
    `CHK("extra", 0, loads.size())
    rchk("pend", `DCR_OFS_PENDING, 16'h0000);
    fire();
    `CHK("none", 0, loads.size())
    $display("trigger test done");
    for (int w = 0; w < 16; w++) begin
      xfer(1'b1, `DCR_OFS_CARD_CTRL, 16'(w));
      rchk("ctrl", `DCR_OFS_CARD_CTRL, 16'(w));
      rchk("win", 6'h3C, win_exp(4'(w), 5'h1C, r));
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      cal_jumper_i <= (k == 2);
      xfer(1'b1, `DCR_OFS_CARD_CTRL, (k > 0) ? 16'h0018 : 16'h0008);
      xfer(1'b1, 6'h20, 16'h1234 + 16'(k));
      rchk("nv", 6'h20, (k == 2) ? 16'h1236 : 16'hA080);
    end
    $display("window test done");
    select_jumper_i <= 16'h00F0;
    vi_jumper_i <= 16'h0000;
    do_reset(1'b1);
    xfer(1'b1, `DCR_OFS_RELAY, 16'h0000);
    xfer(1'b1, `DCR_OFS_MODE, 16'h0000);
    rchk("jmpr8", `DCR_OFS_JUMPER, 16'hFFF0);
    rchk("pend8", `DCR_OFS_PENDING, 16'hFF00);
    rchk("mode8", `DCR_OFS_MODE, 16'hFF00);
    rchk("relay8", `DCR_OFS_RELAY, 16'hFF00);
    rchk("cfg8", `DCR_OFS_CARD_CONFIG, 16'h003D);
    $display("eight channel test done");
    close_out();
  end
endmodule
bind dcr_channel_bank dcr_channel_bank_properties #(.CHANNELS(CHANNELS),
  .RELAY_SETTLE_CYCLES(RELAY_SETTLE_CYCLES)) chk_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .eight_channel_i(eight_channel_i), .select_jumper_i(select_jumper_i),
  .vi_jumper_i(vi_jumper_i), .cal_jumper_i(cal_jumper_i), .bus_req_i(bus_req_i),
  .bus_ready_o(bus_ready_o), .bus_ack_o(bus_ack_o), .ext_req_o(ext_req_o),
  .dac_load_o(dac_load_o), .channel_mode_o(channel_mode_o), .relay_open_o(relay_open_o),
  .relay_busy_o(relay_busy_o), .nv_write_enable_o(nv_write_enable_o));

// ---- verification/dcr_ext_model.sv ----
// far-side model of the extended register space seen through the window
`timescale 1ns/1ps
module dcr_ext_model (
  input wire logic clock_i,
  input wire dcr_pkg::dcr_ext_req_t req_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [256];
  logic [15:0] last;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA000 | 16'(i);
    end
    last = 16'h0000;
  end
  // word index is page above the 32-byte offset, so one page step is 32 bytes
  always @(posedge clock_i) begin
    if (req_i.wr === 1'b1) begin
      mem[req_i.addr[8:1]] <= req_i.wdata;
    end
    if (req_i.rd === 1'b1) begin
      last <= mem[req_i.addr[8:1]];
    end
  end
  // idle data is the inverse of the last word so a late sample cannot pass
  assign rdata_o = (req_i.rd === 1'b1) ? mem[req_i.addr[8:1]] : ~last;
endmodule
